// File: hdl/ums_defines.svh
// Constants for the modem-status input block.
// Assumes inclusion by bare name from hdl/.
`ifndef UMS_DEFINES_SVH
`define UMS_DEFINES_SVH
`define UMS_BIT_DCTS 0
`define UMS_BIT_DDSR 1
`define UMS_BIT_RING_TRAIL 2
`define UMS_BIT_DCARRIER 3
`define UMS_BIT_CTS 4
`define UMS_BIT_DSR 5
`define UMS_BIT_RING 6
`define UMS_BIT_CARRIER 7
`define UMS_STATUS_RST 8'h00
`define UMS_FLAGS_RST 4'h0
`define UMS_PINS_RST 4'hF
`endif

// File: hdl/ums_pkg.sv
// Types for the modem-status input block.
// Assumes ums_defines.svh is available.
package ums_pkg;
    // Active-low modem pins, as sampled
    typedef struct packed {
        logic carrierDetectN;
        logic ringIndicatorN;
        logic dsrN;
        logic ctsN;
    } ums_pins_type;
endpackage : ums_pkg

// File: hdl/ums_sync.sv
// Two-flop synchroniser for the modem pins.
// Assumes pins idle high (inactive) at reset.
`timescale 1ns/1ps
`default_nettype none
`include "ums_defines.svh"
module ums_sync
    import ums_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Pins
    input wire ums_pins_type pinsIn,
    output ums_pins_type pinsOut
);
    ums_pins_type meta_q, meta_d;
    ums_pins_type sync_q, sync_d;

    always_comb
    begin
        meta_d = pinsIn;
        sync_d = meta_q;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta_q <= `UMS_PINS_RST;
            sync_q <= `UMS_PINS_RST;
        end
        else
        begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign pinsOut = sync_q;
endmodule : ums_sync
`default_nettype wire

// File: hdl/ums_modem_status.sv
// Modem-status register logic of a serial port.
// Assumes pins asynchronous; read strobe and enable from same clock.
//
// Summary of operation
// - Status bit 7 is inverted carrier detect
// - Carrier detect change sets its delta flag
// - Carrier change raises interrupt when enabled
// - Status bit 6 is inverted ring indicator
// - Bit 2 set on ring pin rising
// - Bit 6 falling raises interrupt when enabled
// - Status bit 4 is inverted clear-to-send
// - Clear-to-send change sets its delta flag
// - Status bit 5 is inverted data-set-ready
// - Data-set-ready change sets its delta flag
`timescale 1ns/1ps
`default_nettype none
`include "ums_defines.svh"
module ums_modem_status
    import ums_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Modem pins, active low
    input wire logic carrier_detect_n,
    input wire logic ring_indicator_n,
    input wire logic dsrN,
    input wire logic ctsN,
    // Software side
    input wire logic statusRead,
    input wire logic modemIntEnable,
    output logic [7:0] modem_status_reg,
    output logic modemInt
);
    // ***************************************************
    // Pin synchronisation
    // ***************************************************
    ums_pins_type pinsRaw;
    ums_pins_type pinsSync;
    ums_pins_type prev_q, prev_d;
    logic [3:0] flags_q, flags_d;
    logic [7:0] status_q, status_d;
    logic irq_q, irq_d;
    logic carrierChg, ctsChg, dsrChg, ringTrailSet;

    // One test shared by the three delta flags
    function automatic logic level_changed(input logic nowLevel, input logic oldLevel);
        return nowLevel != oldLevel;
    endfunction : level_changed

    assign pinsRaw = '{carrierDetectN: carrier_detect_n, ringIndicatorN: ring_indicator_n,
                       dsrN: dsrN, ctsN: ctsN};

    // Raw pins are asynchronous; nothing below reads them directly
    ums_sync u_ums_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pinsIn(pinsRaw),
        .pinsOut(pinsSync)
    );

    // ***************************************************
    // Change detection and flags
    // ***************************************************
    always_comb
    begin
        prev_d = pinsSync;
        carrierChg = level_changed(pinsSync.carrierDetectN, prev_q.carrierDetectN);
        ctsChg = level_changed(pinsSync.ctsN, prev_q.ctsN);
        dsrChg = level_changed(pinsSync.dsrN, prev_q.dsrN);
        // Pin low to high is status bit 6 one to zero
        ringTrailSet = pinsSync.ringIndicatorN && !prev_q.ringIndicatorN;
        // Set wins over read clear, so no event is lost
        flags_d = statusRead ? `UMS_FLAGS_RST : flags_q;
        flags_d[`UMS_BIT_DCTS] = flags_d[`UMS_BIT_DCTS] | ctsChg;
        flags_d[`UMS_BIT_DDSR] = flags_d[`UMS_BIT_DDSR] | dsrChg;
        flags_d[`UMS_BIT_RING_TRAIL] = flags_d[`UMS_BIT_RING_TRAIL] | ringTrailSet;
        flags_d[`UMS_BIT_DCARRIER] = flags_d[`UMS_BIT_DCARRIER] | carrierChg;
        status_d = {~pinsSync.carrierDetectN, ~pinsSync.ringIndicatorN, ~pinsSync.dsrN,
                    ~pinsSync.ctsN, flags_d};
        // Any held flag keeps the interrupt up while enabled
        irq_d = modemIntEnable && (flags_d != `UMS_FLAGS_RST);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            prev_q <= `UMS_PINS_RST;
            flags_q <= `UMS_FLAGS_RST;
            status_q <= `UMS_STATUS_RST;
            irq_q <= 1'h0;
        end
        else
        begin
            prev_q <= prev_d;
            flags_q <= flags_d;
            status_q <= status_d;
            irq_q <= irq_d;
        end
    end

    assign modem_status_reg = status_q;
    assign modemInt = irq_q;

    // ***************************************************
    // Checks
    // ***************************************************
    // Level bits trail the synchronised pins by one edge
    property p_carrier_level;
        @(posedge clk) disable iff (!rst_n)
        modem_status_reg[`UMS_BIT_CARRIER] == ~$past(pinsSync.carrierDetectN);
    endproperty
    a_carrier_level: assert property (p_carrier_level) else $error("carrier level");

    property p_ring_level;
        @(posedge clk) disable iff (!rst_n)
        modem_status_reg[`UMS_BIT_RING] == ~$past(pinsSync.ringIndicatorN);
    endproperty
    a_ring_level: assert property (p_ring_level) else $error("ring level wrong");

    property p_cts_level;
        @(posedge clk) disable iff (!rst_n)
        modem_status_reg[`UMS_BIT_CTS] == ~$past(pinsSync.ctsN);
    endproperty
    a_cts_level: assert property (p_cts_level) else $error("cts level wrong");

    property p_dsr_level;
        @(posedge clk) disable iff (!rst_n)
        $changed(pinsSync.dsrN) |=> modem_status_reg[`UMS_BIT_DSR] == ~$past(pinsSync.dsrN);
    endproperty
    a_dsr_level: assert property (p_dsr_level) else $error("dsr level wrong");

    property p_dcarrier;
        @(posedge clk) disable iff (!rst_n)
        $changed(pinsSync.carrierDetectN) |=> modem_status_reg[`UMS_BIT_DCARRIER];
    endproperty
    a_dcarrier: assert property (p_dcarrier) else $error("delta carrier missed");

    property p_dcts;
        @(posedge clk) disable iff (!rst_n)
        $changed(pinsSync.ctsN) |=> modem_status_reg[`UMS_BIT_DCTS];
    endproperty
    a_dcts: assert property (p_dcts) else $error("delta cts missed");

    property p_ddsr;
        @(posedge clk) disable iff (!rst_n)
        $changed(pinsSync.dsrN) |=> modem_status_reg[`UMS_BIT_DDSR];
    endproperty
    a_ddsr: assert property (p_ddsr) else $error("delta dsr missed");

    property p_ring_trail;
        @(posedge clk) disable iff (!rst_n)
        $rose(pinsSync.ringIndicatorN) |=> modem_status_reg[`UMS_BIT_RING_TRAIL];
    endproperty
    a_ring_trail: assert property (p_ring_trail) else $error("trailing edge missed");

    property p_irq_carrier;
        @(posedge clk) disable iff (!rst_n)
        ($changed(pinsSync.carrierDetectN) && modemIntEnable) |=> modemInt;
    endproperty
    a_irq_carrier: assert property (p_irq_carrier) else $error("carrier irq missed");

    property p_irq_ring;
        @(posedge clk) disable iff (!rst_n)
        ($fell(modem_status_reg[`UMS_BIT_RING]) && $past(modemIntEnable)) |-> modemInt;
    endproperty
    a_irq_ring: assert property (p_irq_ring) else $error("ring irq missed");

    // A read with no event in its cycle leaves every flag clear
    property p_read_clear;
        @(posedge clk) disable iff (!rst_n)
        (statusRead && !$changed(pinsSync.carrierDetectN) && !$changed(pinsSync.ctsN)
            && !$changed(pinsSync.dsrN) && !$rose(pinsSync.ringIndicatorN))
            |=> (modem_status_reg[3:0] == `UMS_FLAGS_RST) && !modemInt;
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("read did not clear");

    property p_irq_level;
        @(posedge clk) disable iff (!rst_n)
        modemInt == ($past(modemIntEnable) && (modem_status_reg[3:0] != `UMS_FLAGS_RST));
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq level wrong");

    property p_flag_hold;
        @(posedge clk) disable iff (!rst_n)
        !statusRead |=> ((modem_status_reg[3:0] & $past(modem_status_reg[3:0]))
            == $past(modem_status_reg[3:0]));
    endproperty
    a_flag_hold: assert property (p_flag_hold) else $error("flag lost before read");

    property p_carrier_quiet;
        @(posedge clk) disable iff (!rst_n)
        (statusRead && !$changed(pinsSync.carrierDetectN)) |=> !modem_status_reg[`UMS_BIT_DCARRIER];
    endproperty
    a_carrier_quiet: assert property (p_carrier_quiet) else $error("carrier flag stuck");

    property p_cts_quiet;
        @(posedge clk) disable iff (!rst_n)
        (statusRead && !$changed(pinsSync.ctsN)) |=> !modem_status_reg[`UMS_BIT_DCTS];
    endproperty
    a_cts_quiet: assert property (p_cts_quiet) else $error("cts flag stuck");

    property p_dsr_quiet;
        @(posedge clk) disable iff (!rst_n)
        (statusRead && !$changed(pinsSync.dsrN)) |=> !modem_status_reg[`UMS_BIT_DDSR];
    endproperty
    a_dsr_quiet: assert property (p_dsr_quiet) else $error("dsr flag stuck");

    property p_trail_quiet;
        @(posedge clk) disable iff (!rst_n)
        (statusRead && !$rose(pinsSync.ringIndicatorN)) |=> !modem_status_reg[`UMS_BIT_RING_TRAIL];
    endproperty
    a_trail_quiet: assert property (p_trail_quiet) else $error("trail flag stuck");

    property p_irq_needs_enable;
        @(posedge clk) disable iff (!rst_n)
        !$past(modemIntEnable) |-> !modemInt;
    endproperty
    a_irq_needs_enable: assert property (p_irq_needs_enable) else $error("irq not enabled");
endmodule : ums_modem_status
`default_nettype wire

// File: tb/ums_modem_model.sv
// Modem-side model driving the four active-low handshake pins.
// Assumes the bench calls drive() and that the pins idle high.
`timescale 1ns/1ps
`default_nettype none
`include "ums_defines.svh"
module ums_modem_model
    import ums_pkg::*;
(
    // Clock
    input wire logic clk,
    // Pins, active low
    output ums_pins_type pins
);
    // Changes land at the falling edge, well clear of sampling
    task automatic drive(input ums_pins_type p);
        @(negedge clk);
        pins = p;
    endtask : drive
    initial pins = `UMS_PINS_RST;
endmodule : ums_modem_model
`default_nettype wire

// File: tb/tb_ums_modem_status.sv
// Self-checking bench for the modem-status block.
// Assumes a 50 MHz clock and the modem model on the pin side.
`timescale 1ns/1ps
`default_nettype none
`include "ums_defines.svh"
`define CHK(a, b) check(a, b)
module tb_ums_modem_status
    import ums_pkg::*;
;
    // ************************
    // Signals and instances
    // ************************
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic statusRead = 1'h0;
    logic modemIntEnable = 1'h0;
    logic [7:0] modem_status_reg;
    logic modemInt;
    ums_pins_type pins;
    int err_total = 0;
    int checked = 0;
    int cycles = 0;
    ums_modem_model u_ums_modem_model (.clk(clk), .pins(pins));
    ums_modem_status u_ums_modem_status (.clk(clk), .rst_n(rst_n),
        .carrier_detect_n(pins.carrierDetectN), .ring_indicator_n(pins.ringIndicatorN),
        .dsrN(pins.dsrN),
        .ctsN(pins.ctsN), .statusRead(statusRead), .modemIntEnable(modemIntEnable),
        .modem_status_reg(modem_status_reg), .modemInt(modemInt));
    initial forever #10 clk = ~clk;
    // ************************
    // Shared tasks
    // ************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    task automatic stop_test;
        $display("Counts: checked=%0d mismatches=%0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    // Generous ceiling; the whole run needs well under 200 cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            err_total++;
            stop_test();
        end
    end
    task automatic read_status;
        @(negedge clk);
        statusRead = 1'h1;
        @(negedge clk);
        statusRead = 1'h0;
    endtask : read_status
    // ************************
    // Scenarios
    // ************************
    task automatic test_reset;
        repeat (4) @(negedge clk);
        `CHK({modem_status_reg[7:1], modemInt}, 8'h00);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        `CHK(modem_status_reg, `UMS_STATUS_RST);
        $display("test_reset done");
    endtask : test_reset
    // Ring falling alone must not raise a flag; all pins together last
    task automatic test_pins;
        ums_pins_type seq [8] = '{4'h7, 4'hF, 4'hB, 4'hF, 4'hD, 4'hE, 4'h0, 4'hF};
        ums_pins_type prev;
        logic [7:0] exp;
        prev = `UMS_PINS_RST;
        foreach (seq[i])
        begin
            modemIntEnable = (i % 2 == 1);
            u_ums_modem_model.drive(seq[i]);
            repeat (4) @(negedge clk);
            exp = {~seq[i].carrierDetectN, ~seq[i].ringIndicatorN, ~seq[i].dsrN,
                ~seq[i].ctsN, seq[i].carrierDetectN ^ prev.carrierDetectN,
                seq[i].ringIndicatorN & ~prev.ringIndicatorN,
                seq[i].dsrN ^ prev.dsrN, seq[i].ctsN ^ prev.ctsN};
            `CHK(modem_status_reg, exp);
            `CHK({7'h00, modemInt}, {7'h00, modemIntEnable & (|exp[3:0])});
            read_status();
            `CHK({modem_status_reg[3:0], 3'h0, modemInt}, 8'h00);
            prev = seq[i];
        end
        $display("test_pins done");
    endtask : test_pins
    // Reset with flags pending; pins held low at release read as changes
    task automatic test_midreset;
        modemIntEnable = 1'h1;
        u_ums_modem_model.drive(4'h0);
        repeat (4) @(negedge clk);
        rst_n = 1'h0;
        @(negedge clk);
        `CHK(modem_status_reg, `UMS_STATUS_RST);
        `CHK({7'h00, modemInt}, 8'h00);
        rst_n = 1'h1;
        repeat (4) @(negedge clk);
        `CHK(modem_status_reg, 8'hFB);
        `CHK({7'h00, modemInt}, 8'h01);
        read_status();
        `CHK(modem_status_reg, 8'hF0);
        `CHK({7'h00, modemInt}, 8'h00);
        $display("test_midreset done");
    endtask : test_midreset
    initial
    begin
        test_reset();
        test_pins();
        test_midreset();
        stop_test();
    end
endmodule : tb_ums_modem_status
`default_nettype wire
